// ---- design/odi_cfg.svh ----
`ifndef ODI_CFG_SVH
`define ODI_CFG_SVH

// register offsets, slot a
`define OFS_SAMPLE_KIND 15'h0120
`define OFS_PATH_CONFIG 15'h0121
`define OFS_INPUT_ENABLE 15'h0122
`define OFS_PRECONDITION 15'h0123
`define OFS_AMP_GAIN 15'h0124
`define OFS_BUFFER_CAP 15'h0125
`define OFS_LED_CURRENT 15'h0128
`define OFS_LED_SELECT 15'h0129
`define OFS_COUNT_REPEAT 15'h012a
`define OFS_PERIOD 15'h012b
`define OFS_LED_TIMING 15'h012c
`define OFS_LIT_OFFSET 15'h0138
`define OFS_DARK_OFFSETS 15'h0139

// register indices inside the local file
`define IDX_SAMPLE_KIND 4'h0
`define IDX_PATH_CONFIG 4'h1
`define IDX_LED_CURRENT 4'h6
`define IDX_LED_SELECT 4'h7
`define IDX_COUNT_REPEAT 4'h8
`define IDX_PERIOD 4'h9
`define IDX_LED_TIMING 4'ha
`define IDX_LIT_OFFSET 4'hb
`define IDX_DARK_OFFSETS 4'hc
`define IDX_NONE 4'hf
`define REG_COUNT 13

// field positions
`define KIND_MSB 13
`define KIND_LSB 11
`define KIND_ONE_REGION 3'h2
`define KIND_TWO_REGION 3'h3
`define DARK_OUT_EN_BIT 0
`define REG_RESET 16'h0000

// timing: one conversion every microsecond
`define CLK_PERIOD_NS 25
`define SAMPLE_INTERVAL_NS 1000
`define CYCLES_PER_US (`SAMPLE_INTERVAL_NS / `CLK_PERIOD_NS)

`endif

// ---- design/odi_pkg.sv ----
package odi_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RUN,
    S_SETTLE,
    S_WR_SIG,
    S_WR_DARK
  } seq_state_t;

  typedef struct packed {
    logic wr;
    logic is_dark;
    logic [31:0] data;
  } fifo_word_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } tick_state_t;

  typedef struct packed {
    logic [31:0] lit;
    logic [31:0] dark;
    logic take_lit;
    logic take_dark;
  } acc_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [9:0] t_us;
    logic [7:0] rep;
    logic take_lit;
    logic take_dark;
    logic adc_start;
    logic led_on;
    fifo_word_t fifo;
    logic [15:0] rdata;
    logic [12:0][15:0] regs;
  } seq_full_t;

endpackage : odi_pkg

// ---- design/odi_seq.sv ----
// Notes on behaviour
// - one conversion per microsecond in lit and dark regions, samples summed.
// - led pulses only inside the led window, never in a dark region.
// - after the last repeat, lit sum minus dark sum goes to the fifo.
// - the dark sum can follow the signal word into the fifo.
// - one-region: all dark samples, as many as lit, in the leading region.
// - two-region: equal counts, dark split between leading and trailing regions.
// - two-region fifo result is twice the one-region result.
// - sample kind 0x2 selects one-region, 0x3 two-region integration.
// - upper byte of timing word is conversions per region.
// - lower byte of timing word is repeats per slot.
// - repeat period is the programmed ten-bit field, never computed.
// - nine-bit lit offset is the first lit conversion time.
// - seven-bit leading dark offset is the first dark conversion time.
// - nine-bit trailing dark offset used only in two-region mode.
// - eight-bit led start in microseconds.
// - eight-bit led pulse length in microseconds.
// - two-bit led style and four-bit led select choose the drive.
// - two seven-bit led current fields, one per driven output.
`timescale 1ns/100ps
`include "odi_cfg.svh"

module odi_seq (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [2:0] run_state_select,
  input wire logic slot_start,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [14:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] adc_data,
  output logic [15:0] reg_rdata,
  output logic led_on,
  output logic [3:0] led_output_select,
  output logic [1:0] led_drive_style,
  output logic [6:0] led_drive_level_a,
  output logic [6:0] led_drive_level_b,
  output logic [6:0] frontend_path_code,
  output logic adc_start,
  output logic fifo_wr,
  output logic fifo_is_dark,
  output logic [31:0] fifo_data
);

  odi_pkg::seq_full_t q;
  odi_pkg::seq_full_t next_q;

  // address decode, shared by write and read
  function automatic logic [3:0] reg_index(input logic [14:0] a);
    case (a)
      `OFS_SAMPLE_KIND: reg_index = 4'h0;
      `OFS_PATH_CONFIG: reg_index = 4'h1;
      `OFS_INPUT_ENABLE: reg_index = 4'h2;
      `OFS_PRECONDITION: reg_index = 4'h3;
      `OFS_AMP_GAIN: reg_index = 4'h4;
      `OFS_BUFFER_CAP: reg_index = 4'h5;
      `OFS_LED_CURRENT: reg_index = 4'h6;
      `OFS_LED_SELECT: reg_index = 4'h7;
      `OFS_COUNT_REPEAT: reg_index = 4'h8;
      `OFS_PERIOD: reg_index = 4'h9;
      `OFS_LED_TIMING: reg_index = 4'ha;
      `OFS_LIT_OFFSET: reg_index = 4'hb;
      `OFS_DARK_OFFSETS: reg_index = 4'hc;
      default: reg_index = `IDX_NONE;
    endcase
  endfunction : reg_index

  // window test: start <= t < start + len, in microseconds
  function automatic logic in_win(input logic [9:0] t, input logic [9:0] start, input logic [8:0] len);
    logic [10:0] stop;
    stop = {1'b0, start} + {2'b00, len};
    in_win = ({1'b0, t} >= {1'b0, start}) && ({1'b0, t} < stop);
  endfunction : in_win

  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [2:0] kind;
  logic two_region;
  logic integ_mode;
  logic dark_out_en;
  logic [7:0] n_int;
  logic [7:0] n_rep;
  logic [9:0] period;
  logic [7:0] led_start;
  logic [7:0] led_len;
  logic [8:0] lit_off;
  logic [6:0] dark1_off;
  logic [8:0] dark2_off;
  logic [7:0] dark1_cnt;
  logic [7:0] dark2_cnt;
  logic lit_win;
  logic dark1_win;
  logic dark2_win;
  logic dark_win;
  logic led_win;
  logic standby;
  logic start_slot;
  logic last_us;
  logic last_rep;
  logic tick_us;
  logic [31:0] lit_sum;
  logic [31:0] dark_sum;
  logic [31:0] diff;

  assign wr_idx = reg_index(reg_addr);
  assign rd_idx = reg_index(reg_addr);

  // per-slot field extraction
  assign kind = q.regs[`IDX_SAMPLE_KIND][`KIND_MSB:`KIND_LSB];
  assign two_region = (kind == `KIND_TWO_REGION);
  assign integ_mode = (kind == `KIND_ONE_REGION) || two_region;
  assign dark_out_en = q.regs[`IDX_SAMPLE_KIND][`DARK_OUT_EN_BIT];
  assign n_int = q.regs[`IDX_COUNT_REPEAT][15:8];
  assign n_rep = q.regs[`IDX_COUNT_REPEAT][7:0];
  assign period = q.regs[`IDX_PERIOD][9:0];
  assign led_start = q.regs[`IDX_LED_TIMING][7:0];
  assign led_len = q.regs[`IDX_LED_TIMING][15:8];
  assign lit_off = q.regs[`IDX_LIT_OFFSET][8:0];
  assign dark1_off = q.regs[`IDX_DARK_OFFSETS][6:0];
  assign dark2_off = q.regs[`IDX_DARK_OFFSETS][15:7];

  // dark sample split between the two regions
  assign dark2_cnt = two_region ? (n_int >> 1) : 8'h00;
  assign dark1_cnt = n_int - dark2_cnt;

  // region windows against the running microsecond count
  assign lit_win = in_win(q.t_us, {1'b0, lit_off}, {1'b0, n_int});
  assign dark1_win = in_win(q.t_us, {3'b000, dark1_off}, {1'b0, dark1_cnt});
  assign dark2_win = two_region && in_win(q.t_us, {1'b0, dark2_off}, {1'b0, dark2_cnt});
  assign dark_win = dark1_win || dark2_win;
  assign led_win = in_win(q.t_us, {2'b00, led_start}, {1'b0, led_len});

  // sequencing conditions
  assign standby = (run_state_select == 3'h0);
  assign start_slot = (q.st == odi_pkg::S_IDLE) && slot_start && integ_mode && !standby;
  assign last_us = (period == 10'h000) || (q.t_us == period - 10'h001);
  assign last_rep = ({1'b0, q.rep} + 9'h001) >= ((n_rep == 8'h00) ? 9'h001 : {1'b0, n_rep});
  assign diff = lit_sum - dark_sum;

  us_tick u_tick (
    .clk_sys(clk_sys),
    .srst(srst),
    .clr(start_slot || standby),
    .tick(tick_us)
  );

  sum_acc u_acc (
    .clk_sys(clk_sys),
    .srst(srst),
    .clr(start_slot),
    .take_lit(q.take_lit),
    .take_dark(q.take_dark),
    .sample(adc_data),
    .lit_sum(lit_sum),
    .dark_sum(dark_sum)
  );

  // register file, sequencer and fifo writer
  always_comb begin
    next_q = q;
    next_q.adc_start = 1'b0;
    next_q.take_lit = 1'b0;
    next_q.take_dark = 1'b0;
    next_q.fifo.wr = 1'b0;
    if (reg_wr && (wr_idx != `IDX_NONE)) begin
      next_q.regs[wr_idx] = reg_wdata;
    end
    if (reg_rd) begin
      next_q.rdata = (rd_idx == `IDX_NONE) ? 16'h0000 : q.regs[rd_idx];
    end
    unique case (q.st)
      odi_pkg::S_IDLE: begin
        next_q.led_on = 1'b0;
        if (start_slot) begin
          next_q.st = odi_pkg::S_RUN;
          next_q.t_us = 10'h000;
          next_q.rep = 8'h00;
        end
      end
      odi_pkg::S_RUN: begin
        if (tick_us) begin
          next_q.adc_start = lit_win || dark_win;
          next_q.take_lit = lit_win;
          next_q.take_dark = dark_win && !lit_win;
          next_q.led_on = led_win && !dark_win;
          if (last_us) begin
            next_q.t_us = 10'h000;
            if (last_rep) begin
              next_q.st = odi_pkg::S_SETTLE;
            end else begin
              next_q.rep = q.rep + 8'h01;
            end
          end else begin
            next_q.t_us = q.t_us + 10'h001;
          end
        end
      end
      odi_pkg::S_SETTLE: begin
        // last sample lands in the sums this cycle
        next_q.led_on = 1'b0;
        next_q.st = odi_pkg::S_WR_SIG;
      end
      odi_pkg::S_WR_SIG: begin
        next_q.fifo.wr = 1'b1;
        next_q.fifo.is_dark = 1'b0;
        next_q.fifo.data = two_region ? {diff[30:0], 1'b0} : diff;
        next_q.st = dark_out_en ? odi_pkg::S_WR_DARK : odi_pkg::S_IDLE;
      end
      odi_pkg::S_WR_DARK: begin
        next_q.fifo.wr = 1'b1;
        next_q.fifo.is_dark = 1'b1;
        next_q.fifo.data = two_region ? {dark_sum[30:0], 1'b0} : dark_sum;
        next_q.st = odi_pkg::S_IDLE;
      end
      default: begin
        next_q.st = odi_pkg::S_IDLE;
      end
    endcase
    if (standby) begin
      next_q.st = odi_pkg::S_IDLE;
      next_q.led_on = 1'b0;
      next_q.adc_start = 1'b0;
      next_q.take_lit = 1'b0;
      next_q.take_dark = 1'b0;
      next_q.fifo.wr = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // outputs, all straight from flops
  assign reg_rdata = q.rdata;
  assign led_on = q.led_on;
  assign led_output_select = q.regs[`IDX_LED_SELECT][7:4];
  assign led_drive_style = q.regs[`IDX_LED_SELECT][1:0];
  assign led_drive_level_a = q.regs[`IDX_LED_CURRENT][6:0];
  assign led_drive_level_b = q.regs[`IDX_LED_CURRENT][14:8];
  assign frontend_path_code = q.regs[`IDX_PATH_CONFIG][6:0];
  assign adc_start = q.adc_start;
  assign fifo_wr = q.fifo.wr;
  assign fifo_is_dark = q.fifo.is_dark;
  assign fifo_data = q.fifo.data;

  chk_conv_on_tick: assert property (@(posedge clk_sys) disable iff (srst)
    adc_start |-> $past(tick_us)) else $error("conversion not aligned to microsecond tick");

  chk_led_dark_off: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && dark_win && !standby) |=> !led_on)
    else $error("led lit inside a dark region");

  chk_led_only_run: assert property (@(posedge clk_sys) disable iff (srst)
    led_on |-> $past(q.st) == odi_pkg::S_RUN) else $error("led lit outside the sequence");

  chk_signal_write: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_SETTLE && !standby) |=> ##1 (fifo_wr && !fifo_is_dark))
    else $error("signal word not written after the sequence");

  chk_dark_follows: assert property (@(posedge clk_sys) disable iff (srst)
    (fifo_wr && !fifo_is_dark && dark_out_en && !standby) |=> (fifo_wr && fifo_is_dark))
    else $error("dark word did not follow signal word");

  chk_two_double: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_WR_SIG && two_region && !standby) |=> (fifo_wr && fifo_data[0] == 1'b0))
    else $error("two-region result not doubled");

  chk_no_trailing: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && !two_region && !dark1_win && !standby) |=> !q.take_dark)
    else $error("dark sample outside the leading region in one-region mode");

  chk_dark_split: assert property (@(posedge clk_sys) disable iff (srst)
    integ_mode |-> (((dark1_cnt + dark2_cnt) == n_int)
      && (two_region ? ((dark1_cnt - dark2_cnt) <= 8'h01) : (dark2_cnt == 8'h00))))
    else $error("dark count differs from lit count");

  chk_standby_stop: assert property (@(posedge clk_sys) disable iff (srst)
    standby |=> (q.st == odi_pkg::S_IDLE && !led_on && !adc_start && !fifo_wr))
    else $error("standby did not stop the sequencer");

  // register port behaviour
  chk_rdata_holds: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data changed without a read");

  chk_read_unmapped: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && rd_idx == `IDX_NONE) |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");

  chk_write_lands: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_wr && wr_idx != `IDX_NONE) |=> q.regs[$past(wr_idx)] == $past(reg_wdata))
    else $error("register write did not land");

  // sequencing per microsecond tick, slot start and fifo writes
  chk_led_window: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && !led_win) |=> !led_on) else $error("led lit outside its window");

  chk_conv_in_region: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && (lit_win || dark_win) && !standby) |=> adc_start)
    else $error("conversion missing inside a region");

  chk_lit_wins: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && lit_win && !standby) |=> (q.take_lit && !q.take_dark))
    else $error("lit sample not taken as lit");

  chk_us_step: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && !last_us && !standby) |=> q.t_us == $past(q.t_us) + 10'h001)
    else $error("microsecond count did not advance");

  chk_period_wrap: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && last_us && !standby) |=> q.t_us == 10'h000)
    else $error("period did not wrap at the programmed length");

  chk_repeat_step: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && last_us && !last_rep && !standby)
      |=> (q.st == odi_pkg::S_RUN && q.rep == $past(q.rep) + 8'h01))
    else $error("repeat count did not advance");

  chk_last_repeat: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_RUN && tick_us && last_us && last_rep && !standby) |=> q.st == odi_pkg::S_SETTLE)
    else $error("sequence did not end after the last repeat");

  chk_slot_clears: assert property (@(posedge clk_sys) disable iff (srst)
    start_slot |=> (lit_sum == 32'h0 && dark_sum == 32'h0)) else $error("sums not cleared at slot start");

  chk_start_refused: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_IDLE && (!integ_mode || standby)) |=> q.st == odi_pkg::S_IDLE)
    else $error("slot started in a refused setting");

  chk_no_dark_word: assert property (@(posedge clk_sys) disable iff (srst)
    (q.st == odi_pkg::S_WR_SIG && !dark_out_en && !standby) |=> ##1 !fifo_wr)
    else $error("dark word written while disabled");

endmodule : odi_seq

// ---- design/sum_acc.sv ----
`timescale 1ns/100ps

module sum_acc (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clr,
  input wire logic take_lit,
  input wire logic take_dark,
  input wire logic [15:0] sample,
  output logic [31:0] lit_sum,
  output logic [31:0] dark_sum
);

  odi_pkg::acc_state_t q;
  odi_pkg::acc_state_t next_q;

  // sums persist over repeats, cleared per slot
  always_comb begin
    next_q = q;
    next_q.take_lit = take_lit;
    next_q.take_dark = take_dark;
    if (clr) begin
      next_q.lit = 32'h0;
      next_q.dark = 32'h0;
    end else begin
      if (take_lit) begin
        next_q.lit = q.lit + {16'h0, sample};
      end
      if (take_dark) begin
        next_q.dark = q.dark + {16'h0, sample};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign lit_sum = q.lit;
  assign dark_sum = q.dark;

  chk_lit_adds: assert property (@(posedge clk_sys) disable iff (srst)
    (take_lit && !clr) |=> q.lit == $past(q.lit) + {16'h0, $past(sample)})
    else $error("lit sum did not add the sample");

  chk_dark_adds: assert property (@(posedge clk_sys) disable iff (srst)
    (q.take_dark && !$past(clr)) |-> q.dark == $past(q.dark) + {16'h0, $past(sample)})
    else $error("dark sum did not add the sample");

endmodule : sum_acc

// ---- design/us_tick.sv ----
`timescale 1ns/100ps
`include "odi_cfg.svh"

module us_tick (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clr,
  output logic tick
);

  localparam logic [5:0] LAST = 6'(`CYCLES_PER_US - 1);

  odi_pkg::tick_state_t q;
  odi_pkg::tick_state_t next_q;

  // prescaler, phase restarted at each slot start
  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (clr) begin
      next_q.cnt = 6'h00;
    end else if (q.cnt == LAST) begin
      next_q.cnt = 6'h00;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;

  chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (srst)
    q.tick |=> !q.tick [*8]) else $error("microsecond tick repeated too soon");

endmodule : us_tick

// ---- tb/afe_model.sv ----
`timescale 1ns/100ps

// photodiode front end: each conversion reads the led state
module afe_model #(
  parameter logic [15:0] lit_level = 16'h0100,
  parameter logic [15:0] dark_level = 16'h0040
) (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic led_on,
  input wire logic adc_start,
  output logic [15:0] adc_data
);
  int n_lit = 0;
  int n_dark = 0;

  // result stands while adc_start is high, the sums take it at the next edge
  // junk in every other cycle, so a misaligned take never passes
  always @* begin
    if (adc_start) begin
      adc_data = led_on ? lit_level : dark_level;
    end else begin
      adc_data = 16'hffff;
    end
  end

  // conversion counters, cleared at each slot request
  always @(posedge clk_sys) begin
    if (clr) begin
      n_lit <= 0;
      n_dark <= 0;
    end
    if (adc_start) begin
      if (led_on) begin
        n_lit <= n_lit + 1;
      end else begin
        n_dark <= n_dark + 1;
      end
    end
  end
endmodule : afe_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`include "odi_cfg.svh"

`define CHK(what, exp, got) \
  n_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("mismatch %s exp %0h got %0h", what, exp, got); \
  end

module tb;
  localparam logic [15:0] lit_lvl = 16'h0100;
  localparam logic [15:0] dark_lvl = 16'h0040;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [2:0] run_state_select = 3'h0;
  logic slot_start = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [14:0] reg_addr = 15'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] adc_data;
  logic [15:0] reg_rdata;
  logic led_on;
  logic [3:0] led_output_select;
  logic [1:0] led_drive_style;
  logic [6:0] led_drive_level_a;
  logic [6:0] led_drive_level_b;
  logic [6:0] frontend_path_code;
  logic adc_start;
  logic fifo_wr;
  logic fifo_is_dark;
  logic [31:0] fifo_data;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] rv;
  int hits;

  always #12.5 clk_sys = ~clk_sys;

  odi_seq dut (.clk_sys(clk_sys), .srst(srst), .run_state_select(run_state_select),
    .slot_start(slot_start), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .adc_data(adc_data), .reg_rdata(reg_rdata), .led_on(led_on),
    .led_output_select(led_output_select), .led_drive_style(led_drive_style),
    .led_drive_level_a(led_drive_level_a), .led_drive_level_b(led_drive_level_b),
    .frontend_path_code(frontend_path_code), .adc_start(adc_start), .fifo_wr(fifo_wr),
    .fifo_is_dark(fifo_is_dark), .fifo_data(fifo_data));

  afe_model #(.lit_level(lit_lvl), .dark_level(dark_lvl)) afe (.clk_sys(clk_sys),
    .clr(slot_start), .led_on(led_on), .adc_start(adc_start), .adc_data(adc_data));

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      wrap_up();
    end
  end

  task wr(input logic [14:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [14:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // go plus a one-cycle start request
  task go_start;
    @(posedge clk_sys);
    run_state_select <= 3'h1;
    slot_start <= 1'b1;
    @(posedge clk_sys);
    slot_start <= 1'b0;
  endtask : go_start

  // counts conversions and fifo writes over more than a full slot
  task watch_quiet;
    hits = 0;
    repeat (1700) begin
      @(posedge clk_sys);
      #1 if (fifo_wr !== 1'b0 || adc_start !== 1'b0) hits++;
    end
  endtask : watch_quiet

  task test_regs;
    rd(`OFS_COUNT_REPEAT, rv);
    `CHK("reset_val", 16'h0000, rv)
    wr(`OFS_LED_SELECT, 16'h00a2);
    wr(`OFS_LED_CURRENT, 16'h3355);
    wr(`OFS_PATH_CONFIG, 16'h0028);
    wr(15'h0126, 16'hffff);
    rd(15'h0126, rv);
    `CHK("unmapped", 16'h0000, rv)
    rd(`OFS_LED_CURRENT, rv);
    `CHK("readback", 16'h3355, rv)
    `CHK("led_sel", 4'ha, led_output_select)
    `CHK("led_style", 2'h2, led_drive_style)
    `CHK("level_a", 7'h55, led_drive_level_a)
    `CHK("level_b", 7'h33, led_drive_level_b)
    `CHK("path", 7'h28, frontend_path_code)
    $display("test regs done");
  endtask : test_regs

  // 3 conversions, 2 repeats, 20 us period; lit 7..9, led 6..11, dark from 2, second dark 14
  task setup_timing;
    wr(`OFS_COUNT_REPEAT, 16'h0302);
    wr(`OFS_PERIOD, 16'h0014);
    wr(`OFS_LED_TIMING, 16'h0606);
    wr(`OFS_LIT_OFFSET, 16'h0007);
    wr(`OFS_DARK_OFFSETS, 16'h0702);
  endtask : setup_timing

  task run_slot(input logic [15:0] kind, input int mult, input string name);
    logic [31:0] exp_sig;
    logic [31:0] exp_dark;
    int i;
    exp_sig = 32'(mult * 6 * (lit_lvl - dark_lvl));
    exp_dark = 32'(mult * 6 * dark_lvl);
    wr(`OFS_SAMPLE_KIND, kind);
    go_start();
    i = 0;
    do begin
      @(posedge clk_sys);
      #1 i++;
    end while (fifo_wr !== 1'b1 && i < 3000);
    `CHK("sig_wr", 1'b1, fifo_wr)
    `CHK("signal", exp_sig, fifo_data)
    `CHK("sig_flag", 1'b0, fifo_is_dark)
    `CHK("n_lit", 6, afe.n_lit)
    `CHK("n_dark", 6, afe.n_dark)
    @(posedge clk_sys);
    #1 `CHK("dark_wr", kind[0], fifo_wr)
    if (kind[0]) begin
      `CHK("dark_flag", 1'b1, fifo_is_dark)
      `CHK("dark", exp_dark, fifo_data)
    end
    @(posedge clk_sys);
    run_state_select <= 3'h0;
    $display("test %s done", name);
  endtask : run_slot

  task test_abort;
    wr(`OFS_SAMPLE_KIND, 16'h1001);
    go_start();
    repeat (400) @(posedge clk_sys);
    #1 `CHK("abort_lit", 1'b1, led_on)
    @(posedge clk_sys);
    run_state_select <= 3'h0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK("abort_led", 1'b0, led_on)
    watch_quiet();
    `CHK("abort_quiet", 0, hits)
    $display("test abort done");
  endtask : test_abort

  task test_bad_kind;
    wr(`OFS_SAMPLE_KIND, 16'h0001);
    go_start();
    watch_quiet();
    `CHK("bad_kind", 0, hits)
    @(posedge clk_sys);
    run_state_select <= 3'h0;
    $display("test bad kind done");
  endtask : test_bad_kind

  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    test_regs();
    setup_timing();
    run_slot(16'h1001, 1, "one region");
    run_slot(16'h1000, 1, "one region no dark");
    run_slot(16'h1801, 2, "two region");
    test_abort();
    test_bad_kind();
    run_slot(16'h1001, 1, "rerun");
    wrap_up();
  end
endmodule : tb
